/* File: hdl/mrc_top.sv */
// module: remote command interpreter and service request logic
`timescale 1ns/1ps
// Function
// - clear-status code or device clear clears status bits 2 to 5 and 7
// - data ready bit survives clear-status; cleared when reading is output
// - serial poll or mask write of 00 clears service request bit 6
// - power-up switch on: request after each power-up and internal reset
// - text holds 12 characters, codes 32 to 95, punctuation between them
// - live-text mode shows text and keeps annunciators updated
// - drop text past twelfth until control; odd control gives syntax error
// - live text holds until display code, device clear, error or panel key
// - static text freezes display, annunciators off, blanks after 10 min
// - static or blank restored by display code or unlocked local key
// - preset 0: DC volts, 30mV then auto, hold, 4.5 digits, autozero
// - presets 1 to 7: preset 0 state, own function, one single trigger
// - reading goes to the talking bus as 13 characters
// - exponent E-3 to E+6, 0 to 3 digits before point, spare digits 0
// - overload of either sign sends the fixed overload string
// - another requested output replaces the pending reading
// - interrupted output resumes; trigger, clear, code or reset key abandon it
// - switch query sends 0 for rear or 1 for front then CR LF
// - mask bit 0: each reading sets bit 0 and requests until read or poll
// - mask bit 4: panel request key requests until serial poll
// - fast trigger acts as single trigger without settling delays
// - extended resistance: two-wire, 30M range, 10M reference in parallel
// - status bits set regardless of mask; mask gates the request only
// - mask holds bits 0 to 5 only, written as octal 00 to 77
module mrc_top
	import mrc_pkg::*;
#(
	parameter longint BLANK_CYCLES = MRC_BLANK_CYCLES
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// measurement side, same clock
	input wire logic meas_done,
	input wire mrc_reading_t reading,
	input wire logic internal_error_evt,
	input wire logic cal_error_evt,
	input wire logic internal_reset_evt,
	// panel pins, asynchronous
	input wire mrc_pins_t pins,
	// outputs
	output mrc_cfg_t cfg,
	output logic trigger,
	output mrc_disp_t disp_mode,
	output logic annunciators_on,
	output logic display_blank,
	output logic [7:0] status,
	output logic bus_srq
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	mrc_pins_t s1, s2, s3, pin, pin_q, pin_rise;
	genvar g;
	generate
		for (g = 0; g < $bits(mrc_pins_t); g++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1[g] <= 1'b0;
					s2[g] <= 1'b0;
					s3[g] <= 1'b0;
					pin[g] <= 1'b0;
				end
				else
				begin
					s1[g] <= pins[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g])
						pin[g] <= s3[g];
				end
			end
		end
	endgenerate
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_q <= '0;
		else
			pin_q <= pin;
	end
	assign pin_rise = pin & ~pin_q;
	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go, rd_go, pop;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [1:0] ctrl;
	logic [5:0] mask;
	mrc_out_t out_src;
	logic [3:0] out_idx;
	logic [7:0] out_char;
	logic [7:0] txt [MRC_TEXT_LEN];
	assign wr_go = !awready && !wready && !bvalid;
	assign rd_go = arvalid && arready;
	assign pop = rd_go && araddr == MRC_REG_OUT && ctrl[MRC_CTRL_TALK]
		&& out_src != MRC_OUT_NONE;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= MRC_RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready)
			begin
				w_data <= wdata;
				w_strb <= wstrb;
				wready <= 1'b0;
			end
			if (wr_go)
			begin
				bvalid <= 1'b1;
				bresp <= aw_addr <= MRC_REG_CTRL ? MRC_RESP_OKAY
					: MRC_RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end
	always_comb
	begin
		rd_ok = 1'b1;
		rd_val = 32'h0;
		case (araddr)
			MRC_REG_CTRL: rd_val = {30'h0, ctrl};
			MRC_REG_STATUS: rd_val = {12'h0, out_src, disp_mode, 2'h0,
				mask, status};
			MRC_REG_OUT: rd_val = {23'h0, pop, pop ? out_char : 8'h00};
			MRC_REG_CFG: rd_val = {14'h0, cfg};
			MRC_REG_TEXT0: rd_val = {txt[3], txt[2], txt[1], txt[0]};
			MRC_REG_TEXT0 + 8'h04: rd_val = {txt[7], txt[6], txt[5], txt[4]};
			MRC_REG_TEXT0 + 8'h08:
				rd_val = {txt[11], txt[10], txt[9], txt[8]};
			default: rd_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= MRC_RESP_OKAY;
		end
		else if (rd_go)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_val;
			rresp <= rd_ok ? MRC_RESP_OKAY : MRC_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ctrl <= 2'h0;
		else if (wr_go && aw_addr == MRC_REG_CTRL && w_strb[0])
			ctrl <= w_data[1:0];
	end
	// ----------------------------------------
	// command decode
	// ----------------------------------------
	logic cmd_go, code_ok, is_text, syn_err, dcl, get, poll, home;
	logic [7:0] op, arg;
	assign cmd_go = wr_go && aw_addr == MRC_REG_CMD && w_strb[1:0] == 2'h3;
	assign op = w_data[15:8];
	assign arg = w_data[7:0];
	assign dcl = wr_go && aw_addr == MRC_REG_BUSEV && w_data[MRC_EV_DCL];
	assign get = wr_go && aw_addr == MRC_REG_BUSEV && w_data[MRC_EV_GET];
	assign poll = wr_go && aw_addr == MRC_REG_BUSEV && w_data[MRC_EV_POLL];
	assign is_text = cmd_go && op == MRC_OP_TEXT;
	assign home = code_ok && op == MRC_OP_HOME;
	always_comb
	begin
		code_ok = 1'b0;
		case (op)
			MRC_OP_CLEAR, MRC_OP_SWQ: code_ok = 1'b1;
			MRC_OP_MASK: code_ok = arg[7:6] == 2'h0;
			MRC_OP_DISP: code_ok = arg >= 8'h01 && arg <= 8'h03;
			MRC_OP_HOME: code_ok = arg <= 8'h07;
			MRC_OP_TRIG: code_ok = arg >= 8'h01 && arg <= 8'h05;
			MRC_OP_FUNC: code_ok = arg >= 8'h01 && arg <= 8'h07;
			MRC_OP_DIGITS: code_ok = arg >= 8'h03 && arg <= 8'h05;
			MRC_OP_AZERO: code_ok = arg <= 8'h01;
			default: code_ok = 1'b0;
		endcase
		code_ok = code_ok && cmd_go;
	end
	// ----------------------------------------
	// text entry
	// ----------------------------------------
	logic [3:0] txt_cnt;
	logic txt_mode, txt_syn, punct;
	assign txt_mode = disp_mode != MRC_DSP_NORMAL;
	assign punct = arg == 8'h2c || arg == 8'h2e || arg == 8'h3b;
	always_comb
	begin
		txt_syn = 1'b0;
		if (is_text)
		begin
			if (!txt_mode || arg > MRC_CHAR_MAX)
				txt_syn = 1'b1;
			else if (arg < MRC_CHAR_MIN)
				txt_syn = !(arg >= 8'h09 && arg <= 8'h0d);
		end
	end
	assign syn_err = (cmd_go && !code_ok && !is_text) || txt_syn;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || (code_ok && op == MRC_OP_DISP))
		begin
			txt_cnt <= 4'h0;
			for (int i = 0; i < MRC_TEXT_LEN; i++)
				txt[i] <= MRC_CHAR_MIN;
		end
		else if (is_text && !txt_syn && txt_mode)
		begin
			// punctuation rides on the previous character's top bit
			if (arg < MRC_CHAR_MIN)
				txt_cnt <= 4'h0;
			else if (punct && txt_cnt != 4'h0 && !txt[txt_cnt - 4'h1][7])
				txt[txt_cnt - 4'h1][7] <= 1'b1;
			else if (txt_cnt < 4'(MRC_TEXT_LEN))
			begin
				txt[txt_cnt] <= arg;
				txt_cnt <= txt_cnt + 4'h1;
			end
		end
	end
	// ----------------------------------------
	// display mode
	// ----------------------------------------
	mrc_disp_t next_disp;
	logic [MRC_BLANK_W-1:0] blank_cnt;
	logic err_evt, key_any, local_ok;
	assign err_evt = syn_err || internal_error_evt || cal_error_evt;
	assign key_any = pin_rise.key_local || pin_rise.key_srq
		|| pin_rise.key_other || pin_rise.key_reset_seq;
	assign local_ok = pin_rise.key_local && !ctrl[MRC_CTRL_LLO];
	always_comb
	begin
		next_disp = disp_mode;
		if (code_ok && op == MRC_OP_DISP)
			next_disp = mrc_disp_t'(arg[1:0] - 2'h1);
		else
			case (disp_mode)
				MRC_DSP_LIVE:
					if (dcl || err_evt || key_any)
						next_disp = MRC_DSP_NORMAL;
				MRC_DSP_STATIC:
					if (local_ok)
						next_disp = MRC_DSP_NORMAL;
					else if (blank_cnt >= MRC_BLANK_W'(BLANK_CYCLES - 1))
						next_disp = MRC_DSP_BLANK;
				MRC_DSP_BLANK:
					if (local_ok)
						next_disp = MRC_DSP_NORMAL;
				default: next_disp = disp_mode;
			endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			disp_mode <= MRC_DSP_NORMAL;
			annunciators_on <= 1'b1;
			display_blank <= 1'b0;
			blank_cnt <= '0;
		end
		else
		begin
			disp_mode <= next_disp;
			annunciators_on <= next_disp == MRC_DSP_NORMAL
				|| next_disp == MRC_DSP_LIVE;
			display_blank <= next_disp == MRC_DSP_BLANK;
			if (next_disp != MRC_DSP_STATIC || disp_mode != MRC_DSP_STATIC)
				blank_cnt <= '0;
			else
				blank_cnt <= blank_cnt + 1'b1;
		end
	end
	// ----------------------------------------
	// meter configuration and trigger
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg <= '{MRC_FUNC_DCV, MRC_RANGE_30MV, 1'b1, MRC_TRIG_INT,
				MRC_DIGITS_HOME, 1'b1, 1'b0, 1'b0, 1'b0};
			trigger <= 1'b0;
		end
		else
		begin
			trigger <= get || (home && arg != 8'h00) || (code_ok
				&& op == MRC_OP_TRIG && (arg[2:0] == MRC_TRIG_SINGLE
				|| arg[2:0] == MRC_TRIG_FAST));
			if (home)
			begin
				cfg <= '{MRC_FUNC_DCV, MRC_RANGE_30MV, 1'b1, MRC_TRIG_HOLD,
					MRC_DIGITS_HOME, 1'b1, 1'b0, 1'b0, 1'b0};
				if (arg != 8'h00)
				begin
					cfg.func <= arg[2:0];
					cfg.trig <= MRC_TRIG_SINGLE;
				end
			end
			else if (code_ok && op == MRC_OP_FUNC)
				cfg.func <= arg[2:0];
			else if (code_ok && op == MRC_OP_TRIG)
			begin
				cfg.trig <= arg[2:0];
				cfg.ext_trig <= arg[2:0] == MRC_TRIG_EXT;
				cfg.skip_settle <= arg[2:0] == MRC_TRIG_FAST;
			end
			else if (code_ok && op == MRC_OP_DIGITS)
				cfg.digits <= arg[2:0];
			else if (code_ok && op == MRC_OP_AZERO)
				cfg.autozero <= arg[0];
			else if (cfg.func == MRC_FUNC_XOHM)
			begin
				// applied after the preset so the fixed range wins
				cfg.func <= MRC_FUNC_OHM2;
				cfg.range <= MRC_RANGE_30MOHM;
				cfg.autorange <= 1'b0;
				cfg.ref_res <= 1'b1;
			end
			if (home || (code_ok && op == MRC_OP_FUNC))
				cfg.ref_res <= 1'b0;
		end
	end
	// ----------------------------------------
	// output formatting
	// ----------------------------------------
	function automatic logic [7:0] read_char(mrc_reading_t r,
		logic [3:0] i, logic [2:0] nd);
		logic [3:0] k;
		logic [3:0] d;
		logic [1:0] dp;
		k = 4'h0;
		d = 4'h0;
		dp = r.ovld ? 2'h1 : r.dp;
		read_char = 8'h20;
		if (i == 4'h0)
			read_char = (r.neg && !r.ovld) ? 8'h2d : 8'h2b;
		else if (i <= 4'h7)
		begin
			k = (i - 4'h1 < {2'h0, dp}) ? i - 4'h1 : i - 4'h2;
			d = r.ovld ? 4'h9 : r.digits[3'(5 - k)];
			if (!r.ovld && ((k == 4'h5 && nd < 3'h5)
				|| (k == 4'h4 && nd < 3'h4)))
				d = 4'h0;
			read_char = (i - 4'h1 == {2'h0, dp}) ? 8'h2e : {4'h3, d};
		end
		else if (i == 4'h8)
			read_char = 8'h45;
		else if (i == 4'h9)
			read_char = (!r.ovld && r.exp == 2'h0) ? 8'h2d : 8'h2b;
		else if (i == 4'ha)
			read_char = r.ovld ? 8'h39 : (r.exp == 2'h0 ? 8'h33
				: r.exp == 2'h1 ? 8'h30 : r.exp == 2'h2 ? 8'h33 : 8'h36);
		else if (i == 4'hb)
			read_char = 8'h0d;
		else
			read_char = 8'h0a;
	endfunction
	mrc_reading_t rd;
	logic rd_avail, rd_done, abandon;
	assign abandon = get || dcl || code_ok
		|| pin_rise.key_reset_seq;
	assign rd_done = pop && out_src == MRC_OUT_READ
		&& out_idx == MRC_READ_LAST;
	always_comb
	begin
		if (out_src == MRC_OUT_SW)
			out_char = out_idx == 4'h0 ? {7'h18, pin.front_sw}
				: out_idx == 4'h1 ? 8'h0d : 8'h0a;
		else
			out_char = read_char(rd, out_idx, cfg.digits);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd <= '0;
			rd_avail <= 1'b0;
			out_src <= MRC_OUT_NONE;
			out_idx <= 4'h0;
		end
		else
		begin
			// a reading arriving mid-output replaces the rest of it
			if (meas_done)
				rd <= reading;
			if (meas_done)
				rd_avail <= 1'b1;
			else if (abandon || rd_done)
				rd_avail <= 1'b0;
			if (code_ok && op == MRC_OP_SWQ)
			begin
				out_src <= MRC_OUT_SW;
				out_idx <= 4'h0;
			end
			else if (abandon)
				out_src <= MRC_OUT_NONE;
			else if (pop)
			begin
				// index is kept between talks, so output resumes
				out_idx <= out_idx + 4'h1;
				if (out_idx == (out_src == MRC_OUT_SW ? MRC_SW_LAST
					: MRC_READ_LAST))
					out_src <= MRC_OUT_NONE;
			end
			else if (out_src == MRC_OUT_NONE && rd_avail)
			begin
				out_src <= MRC_OUT_READ;
				out_idx <= 4'h0;
			end
		end
	end
	// ----------------------------------------
	// status byte and service request
	// ----------------------------------------
	logic [7:0] set_st;
	logic req, req_q, clr_st, pon_evt, rqs_clr;
	logic [2:0] pon_cnt;
	assign clr_st = (code_ok && op == MRC_OP_CLEAR) || dcl;
	assign req = |(status[5:0] & mask) || status[MRC_ST_PON];
	assign pon_evt = pin.pon_sw && (internal_reset_evt
		|| pon_cnt == 3'h1);
	assign rqs_clr = poll || !req || (code_ok && op == MRC_OP_MASK
		&& arg[5:0] == 6'h00);
	always_comb
	begin
		set_st = 8'h00;
		set_st[MRC_ST_DRDY] = meas_done;
		set_st[MRC_ST_SYN] = syn_err;
		set_st[MRC_ST_INT] = internal_error_evt;
		set_st[MRC_ST_KEY] = pin_rise.key_srq;
		set_st[MRC_ST_CAL] = cal_error_evt;
		set_st[MRC_ST_PON] = pon_evt;
		set_st[MRC_ST_RQS] = req && !req_q;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			status <= 8'h00;
			bus_srq <= 1'b0;
			mask <= 6'h00;
			req_q <= 1'b0;
			pon_cnt <= MRC_PON_SETTLE;
		end
		else
		begin
			req_q <= req;
			if (pon_cnt != 3'h0)
				pon_cnt <= pon_cnt - 3'h1;
			if (code_ok && op == MRC_OP_MASK)
				mask <= arg[5:0];
			for (int b = 0; b < 8; b++)
				if (set_st[b])
					status[b] <= 1'b1;
				else if (b == MRC_ST_DRDY)
				begin
					if (rd_done || home)
						status[b] <= 1'b0;
				end
				else if (b == MRC_ST_RQS)
				begin
					if (rqs_clr)
						status[b] <= 1'b0;
				end
				else if (clr_st)
					status[b] <= 1'b0;
			bus_srq <= set_st[MRC_ST_RQS] || (status[MRC_ST_RQS]
				&& !rqs_clr);
		end
	end
endmodule

/* File: hdl/mrc_pkg.sv */
// package: constants and types of the meter remote command block
package mrc_pkg;
	// ----------------------------------------
	// register map and fields
	// ----------------------------------------
	localparam logic [7:0] MRC_REG_CMD = 8'h00;
	localparam logic [7:0] MRC_REG_BUSEV = 8'h04;
	localparam logic [7:0] MRC_REG_CTRL = 8'h08;
	localparam logic [7:0] MRC_REG_STATUS = 8'h0c;
	localparam logic [7:0] MRC_REG_OUT = 8'h10;
	localparam logic [7:0] MRC_REG_CFG = 8'h14;
	localparam logic [7:0] MRC_REG_TEXT0 = 8'h18;
	localparam int MRC_EV_DCL = 0;
	localparam int MRC_EV_GET = 1;
	localparam int MRC_EV_POLL = 2;
	localparam int MRC_CTRL_TALK = 0;
	localparam int MRC_CTRL_LLO = 1;
	localparam int MRC_ST_DRDY = 0;
	localparam int MRC_ST_SYN = 2;
	localparam int MRC_ST_INT = 3;
	localparam int MRC_ST_KEY = 4;
	localparam int MRC_ST_CAL = 5;
	localparam int MRC_ST_RQS = 6;
	localparam int MRC_ST_PON = 7;
	localparam logic [1:0] MRC_RESP_OKAY = 2'h0;
	localparam logic [1:0] MRC_RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// command opcodes
	// ----------------------------------------
	localparam logic [7:0] MRC_OP_CLEAR = 8'h01;
	localparam logic [7:0] MRC_OP_MASK = 8'h02;
	localparam logic [7:0] MRC_OP_DISP = 8'h03;
	localparam logic [7:0] MRC_OP_HOME = 8'h04;
	localparam logic [7:0] MRC_OP_TRIG = 8'h05;
	localparam logic [7:0] MRC_OP_FUNC = 8'h06;
	localparam logic [7:0] MRC_OP_SWQ = 8'h07;
	localparam logic [7:0] MRC_OP_TEXT = 8'h08;
	localparam logic [7:0] MRC_OP_DIGITS = 8'h09;
	localparam logic [7:0] MRC_OP_AZERO = 8'h0a;
	// ----------------------------------------
	// values, counts and timing
	// ----------------------------------------
	localparam int MRC_TEXT_LEN = 12;
	localparam logic [3:0] MRC_READ_LAST = 4'hc;
	localparam logic [3:0] MRC_SW_LAST = 4'h2;
	localparam logic [7:0] MRC_CHAR_MIN = 8'h20;
	localparam logic [7:0] MRC_CHAR_MAX = 8'h5f;
	localparam logic [3:0] MRC_RANGE_30MV = 4'h1;
	localparam logic [3:0] MRC_RANGE_30MOHM = 4'ha;
	localparam logic [2:0] MRC_FUNC_DCV = 3'h1;
	localparam logic [2:0] MRC_FUNC_OHM2 = 3'h3;
	localparam logic [2:0] MRC_FUNC_XOHM = 3'h7;
	localparam logic [2:0] MRC_TRIG_INT = 3'h1;
	localparam logic [2:0] MRC_TRIG_EXT = 3'h2;
	localparam logic [2:0] MRC_TRIG_SINGLE = 3'h3;
	localparam logic [2:0] MRC_TRIG_HOLD = 3'h4;
	localparam logic [2:0] MRC_TRIG_FAST = 3'h5;
	localparam logic [2:0] MRC_DIGITS_HOME = 3'h4;
	localparam logic [2:0] MRC_PON_SETTLE = 3'h5;
	localparam longint MRC_BLANK_MINUTES = 10;
	localparam longint MRC_CLK_PERIOD_NS = 10;
	localparam longint MRC_BLANK_CYCLES =
		MRC_BLANK_MINUTES * 60 * 1000000000 / MRC_CLK_PERIOD_NS;
	localparam int MRC_BLANK_W = 36;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MRC_DSP_NORMAL = 2'b00,
		MRC_DSP_LIVE = 2'b01,
		MRC_DSP_STATIC = 2'b10,
		MRC_DSP_BLANK = 2'b11
	} mrc_disp_t;
	typedef enum logic [1:0] {
		MRC_OUT_NONE = 2'b00,
		MRC_OUT_READ = 2'b01,
		MRC_OUT_SW = 2'b10
	} mrc_out_t;
	typedef struct packed {
		logic ovld;
		logic neg;
		logic [5:0][3:0] digits;
		logic [1:0] dp;
		logic [1:0] exp;
	} mrc_reading_t;
	typedef struct packed {
		logic pon_sw;
		logic front_sw;
		logic key_local;
		logic key_srq;
		logic key_other;
		logic key_reset_seq;
	} mrc_pins_t;
	typedef struct packed {
		logic [2:0] func;
		logic [3:0] range;
		logic autorange;
		logic [2:0] trig;
		logic [2:0] digits;
		logic autozero;
		logic ext_trig;
		logic skip_settle;
		logic ref_res;
	} mrc_cfg_t;
endpackage

/* File: test/mrc_top_properties.sv */
// checker: concurrent properties of the remote command block
`timescale 1ns/1ps
module mrc_top_properties
	import mrc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched ports
	input wire logic meas_done,
	input wire mrc_cfg_t cfg,
	input wire mrc_disp_t disp_mode,
	input wire logic annunciators_on,
	input wire logic display_blank,
	input wire logic [7:0] status,
	input wire logic bus_srq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// display
	// ----------------------------------------
	// two cycles allow the mode and its outputs one cycle of skew
	AST_LIVE_ANN: assert property (
		(disp_mode == MRC_DSP_LIVE) [*2] |-> annunciators_on)
		else $error("annunciators dark in live text");
	AST_STATIC_ANN: assert property (
		(disp_mode == MRC_DSP_STATIC) [*2] |-> !annunciators_on)
		else $error("annunciators lit in static text");
	AST_BLANK: assert property (
		(disp_mode == MRC_DSP_BLANK) [*2] |-> display_blank)
		else $error("blank mode without blank display");
	// ----------------------------------------
	// configuration
	// ----------------------------------------
	AST_FAST: assert property (
		(cfg.trig == MRC_TRIG_FAST) [*2] |-> cfg.skip_settle)
		else $error("fast trigger keeps settling");
	AST_XOHM: assert property (
		cfg.ref_res |-> cfg.func == MRC_FUNC_OHM2 &&
		cfg.range == MRC_RANGE_30MOHM && !cfg.autorange)
		else $error("reference resistor outside extended range");
	// ----------------------------------------
	// status and request
	// ----------------------------------------
	AST_DRDY: assert property (
		meas_done |=> status[0])
		else $error("data ready not set");
	AST_RQS_CAUSE: assert property (
		$rose(status[6]) |-> status[7] || (|status[5:0]))
		else $error("request bit without cause");
	AST_SRQ_BIT: assert property (
		$rose(bus_srq) |-> ##[0:2] status[6])
		else $error("request line without request bit");
	AST_SRQ_DROP: assert property (
		$fell(status[6]) |-> !bus_srq)
		else $error("request line held after bit cleared");
	cover property ($rose(status[6]));
	cover property ($rose(display_blank));
	cover property ($rose(cfg.ref_res));
endmodule

bind mrc_top mrc_top_properties chk (
	.aclk(aclk), .aresetn(aresetn), .meas_done(meas_done), .cfg(cfg),
	.disp_mode(disp_mode), .annunciators_on(annunciators_on),
	.display_blank(display_blank), .status(status), .bus_srq(bus_srq)
);

/* File: test/mrc_host.sv */
// partner: bus controller model driving the register bus
`timescale 1ns/1ps
module mrc_host
	import mrc_pkg::*;
(
	// clock
	input wire logic aclk,
	// write channels
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
	initial
		{araddr, arvalid, rready} = '0;
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic ad;
		logic dd;
		ad = 0;
		dd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel drops valid at the edge that takes it
		do
		begin
			@(posedge aclk);
			ad |= awready;
			dd |= wready;
			awvalid <= !ad;
			wvalid <= !dd;
		end
		while (!(ad && dd));
		do
			@(posedge aclk);
		while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// mask value always fits two octal digits
	task automatic mask(input logic [5:0] m);
		logic [1:0] r;
		wr(MRC_REG_CMD, {16'h0, MRC_OP_MASK, 2'h0, m}, r);
	endtask
endmodule

/* File: test/mrc_top_bench.sv */
// bench: directed tests of the remote command block
`timescale 1ns/1ps
module mrc_top_bench;
	import mrc_pkg::*;
	localparam longint BLANK = 50;
	logic aclk, aresetn, meas_done, trigger, bus_srq, display_blank;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, annunciators_on;
	logic internal_error_evt, cal_error_evt, internal_reset_evt;
	logic [7:0] awaddr, araddr, status;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	mrc_reading_t reading;
	mrc_pins_t pins;
	mrc_cfg_t cfg;
	mrc_disp_t disp_mode;
	int fail_count, samples_checked, trig_seen;
	mrc_top #(.BLANK_CYCLES(BLANK)) uut (.*);
	mrc_host host (.*);
	initial
	begin
		aclk = 0;
		forever
			#5 aclk = ~aclk;
	end
	always @(posedge aclk)
		if (trigger === 1'b1)
			trig_seen <= trig_seen + 1;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic cmd(input logic [7:0] op, a);
		host.wr(MRC_REG_CMD, {16'h0, op, a}, rs);
		tick(2);
	endtask
	// keys pass a synchroniser, so hold and release for several cycles
	task automatic key(input int k);
		pins[k] <= 1'b1;
		tick(8);
		pins[k] <= 1'b0;
		tick(8);
	endtask
	task automatic meas(input logic ov);
		reading <= {ov, 1'b0, 24'h123456, 2'h1, 2'h2};
		meas_done <= 1'b1;
		tick(1);
		meas_done <= 1'b0;
		tick(2);
	endtask
	task automatic pop(input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			host.rd(MRC_REG_OUT, rv, rs);
			chk("out", rv[8:0], {1'b1, s[i]});
		end
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{aresetn, meas_done, internal_error_evt, cal_error_evt} = '0;
		internal_reset_evt = 0;
		reading = '0;
		pins = '0;
		pins.pon_sw = 1'b1;
		fail_count = 0;
		samples_checked = 0;
		trig_seen = 0;
		tick(20);
		aresetn <= 1'b1;
		tick(10);
		chk("pon", status[7], 1);
		cmd(MRC_OP_CLEAR, 0);
		chk("clr", status, 0);
		internal_reset_evt <= 1'b1;
		tick(1);
		internal_reset_evt <= 1'b0;
		tick(10);
		chk("rst", status[7], 1);
		pins.pon_sw <= 1'b0;
		$display("power-up test done");
		meas(0);
		cmd(8'hff, 0);
		key(2);
		chk("set", status, 8'hd5);
		cmd(MRC_OP_CLEAR, 0);
		chk("keep", status, 8'h01);
		cmd(MRC_OP_HOME, 0);
		chk("home0", cfg, {MRC_FUNC_DCV, MRC_RANGE_30MV, 1'b1,
			MRC_TRIG_HOLD, MRC_DIGITS_HOME, 1'b1, 3'h0});
		chk("erase", status[0], 0);
		for (int n = 1; n < 8; n++)
		begin
			trig_seen = 0;
			cmd(MRC_OP_HOME, n[7:0]);
			tick(2);
			chk("htrig", trig_seen, 1);
			chk("hfunc", {cfg.trig, cfg.func}, {MRC_TRIG_SINGLE,
				n == 7 ? MRC_FUNC_OHM2 : n[2:0]});
		end
		chk("xohm", {cfg.range, cfg.autorange, cfg.ref_res},
			{MRC_RANGE_30MOHM, 2'b01});
		for (int t = 3; t < 6; t += 2)
		begin
			cmd(MRC_OP_TRIG, t[7:0]);
			chk("fast", {cfg.trig, cfg.skip_settle},
				{t[2:0], t == 5});
		end
		$display("preset test done");
		host.mask(6'h14);
		key(2);
		chk("fpsrq", {bus_srq, status}, 9'h150);
		host.wr(MRC_REG_BUSEV, 32'h4, rs);
		tick(2);
		chk("poll", {bus_srq, status}, 9'h010);
		cmd(MRC_OP_CLEAR, 0);
		key(2);
		host.mask(6'h0);
		tick(2);
		chk("m00", {bus_srq, status}, 9'h010);
		host.wr(MRC_REG_BUSEV, 32'h1, rs);
		tick(2);
		chk("dcl", status, 0);
		$display("request test done");
		host.wr(MRC_REG_CTRL, 32'h1, rs);
		host.mask(6'h01);
		cmd(MRC_OP_DIGITS, 5);
		meas(0);
		chk("drdy", {bus_srq, status[6], status[0]}, 3'h7);
		pop("+1.234");
		host.wr(MRC_REG_CTRL, 32'h0, rs);
		host.rd(MRC_REG_OUT, rv, rs);
		host.wr(MRC_REG_CTRL, 32'h1, rs);
		pop("56E+3\r\n");
		tick(2);
		chk("read", {status[6], status[0]}, 0);
		cmd(MRC_OP_DIGITS, 3);
		meas(0);
		pop("+1.23400E+3\r\n");
		meas(1);
		pop("+9.99999E+9\r\n");
		meas(0);
		pop("+1");
		cmd(MRC_OP_AZERO, 1);
		host.rd(MRC_REG_OUT, rv, rs);
		chk("abandon", rv[8], 0);
		for (int f = 0; f < 2; f++)
		begin
			pins.front_sw <= f[0];
			tick(8);
			meas(0);
			cmd(MRC_OP_SWQ, 0);
			pop($sformatf("%0d\r\n", f));
			host.rd(MRC_REG_OUT, rv, rs);
			chk("swend", rv[8], 0);
		end
		$display("output test done");
		cmd(MRC_OP_DISP, 2);
		for (int i = 0; i < 14; i++)
			cmd(MRC_OP_TEXT, 8'h41 + i[7:0]);
		host.rd(MRC_REG_TEXT0 + 8'h08, rv, rs);
		chk("text", rv, 32'h4c4b4a49);
		cmd(MRC_OP_TEXT, 8'h0d);
		chk("live", {status[2], disp_mode, annunciators_on}, 4'h3);
		key(1);
		chk("lkey", disp_mode, MRC_DSP_NORMAL);
		for (int b = 0; b < 2; b++)
		begin
			cmd(MRC_OP_CLEAR, 0);
			cmd(MRC_OP_DISP, 2);
			cmd(MRC_OP_TEXT, b ? 8'h60 : 8'h01);
			chk("bad", {status[2], disp_mode}, 3'h4);
		end
		cmd(MRC_OP_DISP, 3);
		chk("static", {disp_mode, annunciators_on}, 3'h4);
		tick(BLANK + 10);
		chk("blank", display_blank, 1);
		host.wr(MRC_REG_CTRL, 32'h3, rs);
		key(3);
		chk("llo", display_blank, 1);
		host.wr(MRC_REG_CTRL, 32'h1, rs);
		key(3);
		chk("local", disp_mode, MRC_DSP_NORMAL);
		$display("display test done");
		host.rd(8'h40, rv, rs);
		chk("rdmap", {rs, rv[29:0]}, {MRC_RESP_SLVERR, 30'h0});
		host.wr(MRC_REG_STATUS, 32'h0, rs);
		chk("wrmap", rs, MRC_RESP_SLVERR);
		$display("bus test done");
		stop_test();
	end
	initial
	begin
		#500000;
		fail_count++;
		stop_test();
	end
endmodule
